// >>> hdl/spicfp_frame.sv
// serial command frame engine: shift logic on sclk, decode on system clock
`timescale 1ns/1ns
// Function
// - reply to a command goes out only during the following transfer
// - clock count not multiple of 8 or below 16 gives diagnosis reply with error flag set
// - first reply after undervoltage end is the diagnosis word
// - read or write to unused address answers with diagnosis word
// - register reply msb high, diagnosis reply msb low
// - a command arriving while a read reply shifts out is executed
// - msb 0 and lsb 1 requests the diagnosis word
// - write frame: 1, bank, address, content; reply is diagnosis word
// - read frame reply: 1, bank, address, content
// - input sampled on falling sclk, output changes on rising, msb first
// - faulty transfer sets error flag and discards the command
// - rising chip select outside undervoltage reset moves shifted data into addressed register
// - serial output floats while chip select is high
module spicfp_frame
    import spicfp_pkg::*;
#(
    parameter logic [63:0] BANK0_USED = 64'h0000_0000_FFFF_FFFF,
    parameter logic [63:0] BANK1_USED = 64'h0000_0000_FFFF_FFFF
) (
    input  wire logic              CLK_I,
    input  wire logic              SYS_RST_I,
    input  wire logic              SCLK_I,
    input  wire logic              CHIP_SELECT_BAR_I,
    input  wire logic              SI_I,
    input  wire logic              UV_RST_I,
    input  wire logic [14:0]       DIAG_I,
    output logic                   SO_O,
    output logic                   SO_OE_O,
    output logic                   TRANSMISSION_ERROR_FLAG_O,
    output logic                   DIAG_RD_O,
    output logic                   REG_WE_O,
    output logic                   REG_BANK_O,
    output logic [ADDR_W-1:0]      REG_ADDR_O,
    output logic [DATA_W-1:0]      REG_DATA_O
);

    // link side, clocked by sclk
    logic [FRAME_W-1:0] rx_r, rx_nxt;
    logic [FRAME_W-1:0] tx_r, tx_nxt;
    logic [CNT_W-1:0]   fall_cnt_r, fall_cnt_nxt;
    logic [CNT_W-1:0]   rise_cnt_r, rise_cnt_nxt;
    logic               first_w;

    // system side
    logic [CNT_W-1:0]   base_r, base_nxt;
    logic [FRAME_W-1:0] reply_r, reply_nxt;
    logic               reply_diag_r, reply_diag_nxt;
    logic               ter_r, ter_nxt;
    logic               we_r, we_nxt;
    logic               bank_r, bank_nxt;
    logic [ADDR_W-1:0]  addr_r, addr_nxt;
    logic [DATA_W-1:0]  data_r, data_nxt;
    logic               diag_rd_r, diag_rd_nxt;
    logic               cs_d_r, uv_d_r;
    logic               cs_s, uv_s;
    logic [DATA_W-1:0]  mem_r [0:127];

    logic               end_evt, uv_end, wr_go;
    logic [CNT_W-1:0]   nbits;
    logic               err_w, is_wr, is_rd, used_w;
    logic               ter_set, ter_clr;
    logic [6:0]         idx;

    // falling edge samples SI, msb first
    always_comb
    begin
        rx_nxt       = {rx_r[FRAME_W-2:0], SI_I};
        fall_cnt_nxt = fall_cnt_r + 8'h01;
    end

    always_ff @(negedge SCLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            rx_r       <= REPLY_RST;
            fall_cnt_r <= CNT_RST;
        end
        else
        begin
            rx_r       <= rx_nxt;
            fall_cnt_r <= fall_cnt_nxt;
        end
    end

    // rising edge advances SO; later bits pass received data on
    assign first_w = (rise_cnt_r == base_r);

    always_comb
    begin
        rise_cnt_nxt = rise_cnt_r + 8'h01;
        if (first_w)
            tx_nxt = {reply_r[FRAME_W-2:0], 1'b0};
        else
            tx_nxt = {tx_r[FRAME_W-2:0], rx_r[0]};
    end

    always_ff @(posedge SCLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            tx_r       <= REPLY_RST;
            rise_cnt_r <= CNT_RST;
        end
        else
        begin
            tx_r       <= tx_nxt;
            rise_cnt_r <= rise_cnt_nxt;
        end
    end

    // reply of the previous frame leads the transfer
    assign SO_O    = first_w ? reply_r[CMD_BIT] : tx_r[FRAME_W-1];
    assign SO_OE_O = ~CHIP_SELECT_BAR_I;

    spicfp_sync #(
        .W       (2),
        .RST_VAL (2'b10)
    ) u_sync (
        .clk_i (CLK_I),
        .rst_i (SYS_RST_I),
        .d_i   ({CHIP_SELECT_BAR_I, UV_RST_I}),
        .q_o   ({cs_s, uv_s})
    );

    // sclk is idle while chip select is high, so link words are stable here
    assign end_evt = cs_s & ~cs_d_r;
    assign uv_end  = ~uv_s & uv_d_r;
    assign nbits   = fall_cnt_r - base_r;
    assign err_w   = (nbits < MIN_BITS) || (nbits[2:0] != ALIGN_ZERO);
    assign is_wr   = rx_r[CMD_BIT];
    assign is_rd   = ~rx_r[CMD_BIT] & ~rx_r[DIAG_RD_BIT];
    assign idx     = rx_r[BANK_BIT:ADDR_LSB];
    assign used_w  = rx_r[BANK_BIT] ? BANK1_USED[rx_r[ADDR_MSB:ADDR_LSB]]
                                    : BANK0_USED[rx_r[ADDR_MSB:ADDR_LSB]];
    assign ter_clr = end_evt & reply_diag_r;
    assign ter_set = (end_evt & err_w) | uv_end;

    always_comb
    begin
        base_nxt       = base_r;
        reply_nxt      = reply_r;
        reply_diag_nxt = reply_diag_r;
        bank_nxt       = bank_r;
        addr_nxt       = addr_r;
        data_nxt       = data_r;
        wr_go          = 1'b0;
        // set wins over the clear that follows a diagnosis read-out
        ter_nxt        = ter_set | (ter_r & ~ter_clr);
        diag_rd_nxt    = ter_clr;
        if (end_evt)
            base_nxt = fall_cnt_r;
        if (uv_s || uv_end)
        begin
            reply_nxt      = spicfp_diag(DIAG_I, ter_nxt);
            reply_diag_nxt = 1'b1;
        end
        else if (end_evt)
        begin
            // every good frame ending outside undervoltage is decoded, also one sent during a read
            reply_nxt      = spicfp_diag(DIAG_I, ter_nxt);
            reply_diag_nxt = 1'b1;
            if (!err_w && is_wr && used_w)
                wr_go = 1'b1;
            else if (!err_w && is_rd && used_w)
            begin
                reply_nxt      = {1'b1, rx_r[BANK_BIT:ADDR_LSB], mem_r[idx]};
                reply_diag_nxt = 1'b0;
            end
        end
        we_nxt = wr_go;
        if (wr_go)
        begin
            bank_nxt = rx_r[BANK_BIT];
            addr_nxt = rx_r[ADDR_MSB:ADDR_LSB];
            data_nxt = rx_r[DATA_MSB:0];
        end
    end

    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            base_r       <= CNT_RST;
            reply_r      <= REPLY_RST;
            reply_diag_r <= 1'b1;
            ter_r        <= 1'b1;
            we_r         <= 1'b0;
            bank_r       <= 1'b0;
            addr_r       <= '0;
            data_r       <= REG_RST;
            diag_rd_r    <= 1'b0;
            cs_d_r       <= 1'b1;
            uv_d_r       <= 1'b0;
            for (int i = 0; i < 128; i++)
                mem_r[i] <= REG_RST;
        end
        else
        begin
            base_r       <= base_nxt;
            reply_r      <= reply_nxt;
            reply_diag_r <= reply_diag_nxt;
            ter_r        <= ter_nxt;
            we_r         <= we_nxt;
            bank_r       <= bank_nxt;
            addr_r       <= addr_nxt;
            data_r       <= data_nxt;
            diag_rd_r    <= diag_rd_nxt;
            cs_d_r       <= cs_s;
            uv_d_r       <= uv_s;
            if (wr_go)
                mem_r[idx] <= rx_r[DATA_MSB:0];
        end
    end

    assign TRANSMISSION_ERROR_FLAG_O = ter_r;
    assign DIAG_RD_O                 = diag_rd_r;
    assign REG_WE_O                  = we_r;
    assign REG_BANK_O                = bank_r;
    assign REG_ADDR_O                = addr_r;
    assign REG_DATA_O                = data_r;

    err_reply_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        end_evt && err_w && !uv_s |=> !reply_r[CMD_BIT] && reply_r[TER_BIT])
        else $error("faulty frame did not give diagnosis reply");

    err_flag_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        end_evt && err_w |=> ter_r && !we_r [*2])
        else $error("faulty frame not flagged or was executed");

    wr_exec_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        end_evt && !err_w && !uv_s && !uv_end && is_wr && used_w
        |=> we_r && data_r == $past(rx_r[DATA_MSB:0])
            && !reply_r[CMD_BIT] ##1 !we_r)
        else $error("write frame not stored as one pulse");

    rd_reply_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        end_evt && !err_w && !uv_s && !uv_end && is_rd && used_w
        |=> reply_r[CMD_BIT]
            && reply_r[BANK_BIT:ADDR_LSB] == $past(rx_r[BANK_BIT:ADDR_LSB]))
        else $error("read reply lacks leading one or address");

    resv_reply_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        end_evt && !err_w && !used_w && !rx_r[DIAG_RD_BIT]
        |=> !reply_r[CMD_BIT] && !we_r)
        else $error("reserved address not answered with diagnosis");

    diag_req_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        end_evt && !err_w && !rx_r[CMD_BIT] && rx_r[DIAG_RD_BIT]
        |=> !reply_r[CMD_BIT] && reply_diag_r && !we_r)
        else $error("diagnosis request gave another reply");

    uv_reply_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        uv_end |=> !reply_r[CMD_BIT] && ter_r)
        else $error("no diagnosis reply after undervoltage");

    reply_hold_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        !end_evt && !uv_s && !uv_end |=> $stable(reply_r) && $stable(base_r))
        else $error("reply changed outside frame end");

    ter_clear_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        end_evt && reply_diag_r && !err_w && !uv_s && !uv_end
        |=> !ter_r && diag_rd_r)
        else $error("flag not cleared after diagnosis read-out");

endmodule // spicfp_frame

// >>> hdl/spicfp_pkg.sv
// constants and helpers for the serial command frame block
package spicfp_pkg;

    localparam int FRAME_W     = 16;
    localparam int CNT_W       = 8;
    localparam int ADDR_W      = 6;
    localparam int DATA_W      = 8;

    // frame field positions
    localparam int CMD_BIT     = 15;
    localparam int BANK_BIT    = 14;
    localparam int ADDR_MSB    = 13;
    localparam int ADDR_LSB    = 8;
    localparam int DATA_MSB    = 7;
    localparam int DIAG_RD_BIT = 0;
    localparam int TER_BIT     = 10;

    // frame length checks
    localparam logic [CNT_W-1:0] MIN_BITS   = 8'h10;
    localparam logic [2:0]       ALIGN_ZERO = 3'h0;

    // reset values
    localparam logic [DATA_W-1:0]  REG_RST   = 8'h00;
    localparam logic [FRAME_W-1:0] REPLY_RST = 16'h0000;
    localparam logic [CNT_W-1:0]   CNT_RST   = 8'h00;

    // diagnosis word: msb low, transmission error flag at its own bit
    function automatic logic [FRAME_W-1:0] spicfp_diag(
        input logic [14:0] flags,
        input logic        transmission_error_flag
    );
        logic [FRAME_W-1:0] w;
        w          = {1'b0, flags};
        w[TER_BIT] = transmission_error_flag;
        return w;
    endfunction

endpackage

// >>> hdl/spicfp_sync.sv
// two flip-flop level synchroniser with selectable reset value
`timescale 1ns/1ns
module spicfp_sync #(
    parameter int         W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta_r;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            meta_r <= RST_VAL;
            q_o    <= RST_VAL;
        end
        else
        begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end

endmodule // spicfp_sync

// >>> test/spicfp_host.sv
// host side model: serial master that sends frames and collects replies
`timescale 1ns/1ns
module spicfp_host (
    input  wire logic so_i,
    output logic      sclk_o,
    output logic      cs_bar_n_o,
    output logic      si_o
);
    logic [15:0] rx;
    logic [15:0] rxm;
    event        done_e;

    initial
    begin
        sclk_o     = 1'b0;
        cs_bar_n_o = 1'b1;
        si_o       = 1'b0;
        rx         = 16'h0000;
        rxm        = 16'hFFFF;
    end

    // clock stands low between frames; lines rest at their pull levels
    task automatic xfer(input int n, input logic [23:0] w);
        int s;
        s          = (n < 16) ? 16 - n : 0;
        cs_bar_n_o = 1'b0;
        #250;
        for (int i = n - 1; i >= 0; i--)
        begin
            si_o = w[i];
            #3;
            if (n - 1 - i < 16)
                rx = {rx[14:0], so_i};
            sclk_o = 1'b1;
            #6;
            sclk_o = 1'b0;
            #3;
        end
        // a short frame shows only the top bits of the reply
        rx         = rx << s;
        rxm        = 16'hFFFF << s;
        #250;
        si_o       = 1'b0;
        cs_bar_n_o = 1'b1;
        -> done_e;
        #800;
    endtask
endmodule // spicfp_host

// >>> test/tb_top.sv
// self-checking bench for the serial command frame block
`timescale 1ns/1ns
module tb_top;
    logic        clk, rst, uv, so, so_oe, transmission_error_flag, diag_rd, we, bank;
    logic        sclk, cs_bar_n, si;
    logic [14:0] diag;
    logic [5:0]  addr, ad;
    logic [7:0]  data;
    logic [7:0]  mem [2][64];
    logic [15:0] exv [$];
    logic [15:0] exm [$];
    logic [14:0] wq [$];
    int          checks, miscompares, cl, drc;
    int          lens [5] = '{8, 12, 20, 17, 24};

    spicfp_frame uut (.CLK_I(clk), .SYS_RST_I(rst), .SCLK_I(sclk),
        .CHIP_SELECT_BAR_I(cs_bar_n), .SI_I(si), .UV_RST_I(uv),
        .DIAG_I(diag), .SO_O(so), .SO_OE_O(so_oe),
        .TRANSMISSION_ERROR_FLAG_O(transmission_error_flag), .DIAG_RD_O(diag_rd),
        .REG_WE_O(we), .REG_BANK_O(bank), .REG_ADDR_O(addr),
        .REG_DATA_O(data));
    spicfp_host host (.so_i(so), .sclk_o(sclk), .cs_bar_n_o(cs_bar_n),
        .si_o(si));

    always #50 clk = ~clk;

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] s);
        checks++;
        if (s !== e)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic final_report;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // diagnosis form; flag bit compared only where its state is certain
    task automatic push_dg(input logic [14:0] d, input logic t, input bit k);
        exv.push_back({1'b0, d[14:11], t, d[9:0]});
        exm.push_back(k ? 16'hFFFF : 16'hFBFF);
    endtask

    // sends one frame and notes the reply expected in the next one
    task automatic cmd(input int n, input logic [23:0] w);
        logic [14:0] d;
        logic [15:0] f;
        bit          ok;
        int          p;
        bit          dg;
        d  = 15'($urandom);
        f  = w[15:0];
        ok = (n >= 16) && (n % 8 == 0);
        @(posedge clk);
        diag <= d;
        if (!ok)
            push_dg(d, 1'b1, 1);
        else if (!f[15] && f[0])
            push_dg(d, 1'b0, cl >= 1);
        else if (f[13])
            push_dg(d, 1'b0, cl >= 1);
        else if (f[15])
        begin
            mem[f[14]][f[13:8]] = f[7:0];
            wq.push_back(f[14:0]);
            push_dg(d, 1'b0, cl >= 1);
        end
        else
        begin
            exv.push_back({1'b1, f[14:8], mem[f[14]][f[13:8]]});
            exm.push_back(16'hFFFF);
        end
        p  = drc;
        dg = !exv[0][15];
        host.xfer(n, w);
        chk("ter", {15'h0, !ok}, {15'h0, transmission_error_flag});
        chk("diag_rd", {15'h0, dg}, 16'(drc - p));
        cl = ok ? cl + 1 : 0;
    endtask

    always @(host.done_e)
    begin
        chk("reply", exv[0] & exm[0] & host.rxm,
            host.rx & exm[0] & host.rxm);
        void'(exv.pop_front());
        void'(exm.pop_front());
    end

    always @(posedge clk)
    begin
        if (diag_rd === 1'b1)
            drc++;
        if (we === 1'b1)
        begin
            if (wq.size() == 0)
                chk("write", 16'hFFFF, 16'h0000);
            else
                chk("write", {1'b0, wq.pop_front()},
                    {1'b0, bank, addr, data});
        end
    end

    always @(cs_bar_n)
    begin
        #2;
        chk("so_oe", {15'h0, ~cs_bar_n}, {15'h0, so_oe});
    end

    initial
    begin
        #300000;
        miscompares++;
        final_report();
    end

    initial
    begin
        clk  = 1'b0;
        rst  = 1'b1;
        uv   = 1'b0;
        diag = 15'h0000;
        cl   = -1;
        drc  = 0;
        foreach (mem[b, a]) mem[b][a] = 8'h00;
        void'($urandom(29));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        exv.push_back(16'h0000);
        exm.push_back(16'hFFFF);
        cmd(16, 24'h0001);
        $display("test reset done");
        for (int i = 0; i < 8; i++)
        begin
            ad = (i == 0) ? 6'h00 : (i == 1) ? 6'h1F : 6'($urandom % 32);
            cmd(16, {8'h00, 1'b1, i[0], ad, 8'($urandom)});
            cmd(16, {8'h00, 1'b0, i[0], ad, 8'($urandom) & 8'hFE});
        end
        $display("test write read done");
        cmd(16, 24'h00A0A5);
        cmd(16, 24'h007F00);
        $display("test reserved done");
        foreach (lens[k])
            cmd(lens[k], 24'h5AC1AA);
        cmd(16, 24'h0001);
        cmd(16, 24'h0001);
        cmd(16, 24'h0001);
        $display("test faulty frames done");
        @(posedge clk);
        uv <= 1'b1;
        repeat (10) @(posedge clk);
        uv <= 1'b0;
        repeat (10) @(posedge clk);
        void'(exv.pop_back());
        void'(exm.pop_back());
        push_dg(diag, 1'b1, 1);
        cl = 0;
        cmd(16, 24'h8105);
        cmd(16, 24'h0001);
        cmd(16, 24'h0001);
        $display("test undervoltage done");
        final_report();
    end
endmodule // tb_top
